// ===== hw/fbc_core.sv
// Control section of the 4-bit core: pointers, flags, data memory
//
// Contract
// [RULE1] Instruction pointer twelve bits, zero on reset
// [RULE2] Plain instructions advance pointer by length
// [RULE3] Taken jumps load operand target address
// [RULE4] Call saves pointer; return restores it
// [RULE5] Depth bit: reset clears, call/return step
// [RULE6] Depth overflow or underflow forces system reset
// [RULE7] Depth changes only by call, return, reset
// [RULE8] Return store low byte lives in word fifteen
// [RULE9] Word fifteen data access spoils upper bits
// [RULE10] Ten-bit program words; top 22 steps reserved
// [RULE11] Reserved or missing addresses restart at zero
// [RULE12] Four data pages selected by control bits
// [RULE13] Reset clears page zero word zero only
// [RULE14] Table pointer from word zero and control
// [RULE15] Four-bit accumulator, not touched by reset
// [RULE16] Status test sets or clears status flag
// [RULE17] Standby release or ready halt sets flag
// [RULE18] Flagged halt without release clears, no standby
// [RULE19] Test operand picks key, timer, sense terms
// [RULE20] Software configures sense pins before testing
// [RULE21] AND/XOR carry is both bit threes
// [RULE22] Rotates copy old accumulator bit three
// [RULE23] Increment and carry-add: carry if full
// [RULE24] OR, moves and port input clear carry
// [RULE25] Control zero resets to zero except retention
// [RULE26] Other instructions leave carry unchanged
// [RULE27] One clock, synchronous reset of core state
`timescale 1ns/1ps

module fbc_core
  import fbc_pkg::*;
(
  input  wire logic               sys_clk,
  input  wire logic               rst,
  input  wire logic               exec_valid,
  input  wire fbc_op_e            exec_op,
  input  wire logic [IP_W-1:0]    exec_arg,
  input  wire logic [LEN_W-1:0]   exec_len,
  input  wire logic [3:0]         key_inputs,
  input  wire logic               sense_pin_a,
  input  wire logic               sense_pin_b,
  input  wire logic               sense_pin_c,
  input  wire logic               supply_low,
  input  wire logic               timer_zero,
  input  wire logic [7:0]         reg_addr,
  input  wire logic [7:0]         reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic [7:0]              reg_rdata,
  output logic [IP_W-1:0]         instruction_pointer,
  output logic [IP_W-1:0]         table_pointer,
  output logic [NIB_W-1:0]        accumulator,
  output logic                    carry_flag,
  output logic                    status_flag,
  output logic                    standby,
  output logic                    system_reset
);

  //////////////////////////////////////////////////////////////////////////
  // Declarations

  fbc_state_s       s_q;          // Registered state
  fbc_state_s       s_d;          // Next state
  logic [PIN_N-1:0] pins_raw;     // Asynchronous pin levels

  // All pins gathered so one synchroniser serves them
  assign pins_raw = {supply_low, sense_pin_c, sense_pin_b, sense_pin_a,
                     key_inputs};

  //////////////////////////////////////////////////////////////////////////
  // Next-state logic

  // Whole block computed here; the flop process only registers it
  always_comb begin
    logic             do_rst;     // External reset or stack fault
    logic             go;         // Instruction accepted this cycle
    logic [IP_W-1:0]  ip_next;    // Sequential successor address
    logic [3:0]       key_f;      // Filtered key pins
    logic             release_now;// Standby release condition
    logic             cond;       // Status test outcome
    logic [2:0]       tsel;       // Status test selector
    logic [6:0]       midx;       // Data memory index, port side
    logic [6:0]       eidx;       // Data memory index, instruction side
    logic [NIB_W-1:0] a;          // Accumulator before the instruction

    s_d         = s_q;
    do_rst      = rst | s_q.hang;                              // [RULE27]
    go          = exec_valid & ~s_q.standby & ~do_rst;
    ip_next     = s_q.ip + {{(IP_W-LEN_W){1'b0}}, exec_len};
    key_f       = s_q.filt[3:0];
    // Pin c wakes the core only when its stop release is enabled
    release_now = (|key_f) | (s_q.cr1[CR1_STOP_BIT] & s_q.filt[PIN_SC]);
    tsel        = exec_arg[2:0];
    cond        = 1'b0;
    midx        = {s_q.cr0[1:0], reg_addr[4:0]};               // [RULE12]
    eidx        = {s_q.cr0[1:0], exec_arg[4:0]};               // [RULE12]
    a           = s_q.acc;
    s_d.hang    = 1'b0;
    s_d.rdata   = 8'h00;

    // Three-stage pin synchroniser; stage one feeds stage two only
    s_d.s1   = pins_raw;
    s_d.s2   = s_q.s1;
    s_d.s3   = s_q.s2;
    // A level counts once stages two and three agree
    s_d.filt = (~(s_q.s2 ^ s_q.s3) & s_q.s3) |
               ((s_q.s2 ^ s_q.s3) & s_q.filt);

    // Register port read, data valid the following cycle
    if (reg_rd) begin
      if (reg_addr <= ADDR_MEM_TOP) begin
        s_d.rdata = {4'h0, s_q.mem[midx]};
      end else if (reg_addr == ADDR_CR0) begin
        s_d.rdata = s_q.cr0;
      end else if (reg_addr == ADDR_CR1) begin
        s_d.rdata = s_q.cr1;
      end else if (reg_addr == ADDR_STAT) begin
        s_d.rdata = {4'h0, s_q.depth, s_q.standby, s_q.status, s_q.carry};
      end else if (reg_addr == ADDR_ACC) begin
        s_d.rdata = {4'h0, s_q.acc};
      end else begin
        s_d.rdata = 8'h00;            // Unmapped reads as zero
      end
    end

    // Register port write; an instruction in the same cycle wins
    if (reg_wr) begin
      if (reg_addr <= ADDR_MEM_TOP) begin
        // Upper return bits are left as they are, not trusted  [RULE9]
        s_d.mem[midx] = reg_wdata[3:0];
      end else if (reg_addr == ADDR_CR0) begin
        // Retention flag is hardware owned
        s_d.cr0 = {reg_wdata[7:4], s_q.cr0[CR0_RET_BIT], reg_wdata[2:0]};
      end else if (reg_addr == ADDR_CR1) begin
        s_d.cr1 = reg_wdata;
      end
    end

    // Instruction execution
    if (go) begin
      s_d.ip = ip_next;                                        // [RULE2]
      unique case (exec_op)
        // No operation
        FBC_NOP: begin
          s_d.ip = ip_next;
        end
        // Always jump
        FBC_JMP: begin
          s_d.ip = exec_arg;                                   // [RULE3]
        end
        // Jump if carry
        FBC_JC: begin
          if (s_q.carry) begin
            s_d.ip = exec_arg;                                 // [RULE3]
          end
        end
        // Jump if no carry
        FBC_JNC: begin
          if (!s_q.carry) begin
            s_d.ip = exec_arg;                                 // [RULE3]
          end
        end
        // Jump if status
        FBC_JF: begin
          if (s_q.status) begin
            s_d.ip = exec_arg;                                 // [RULE3]
          end
        end
        // Jump if no status
        FBC_JNF: begin
          if (!s_q.status) begin
            s_d.ip = exec_arg;                                 // [RULE3]
          end
        end
        // One nesting level
        FBC_CALL: begin
          if (s_q.depth) begin
            // Second nesting level does not exist: hang     [RULE6]
            s_d.hang = 1'b1;
            s_d.ip   = s_q.ip;
          end else begin
            // Save successor, then jump                  [RULE4] [RULE8]
            s_d.ras_hi          = ip_next[11:8];
            s_d.mem[IDX_W15_HI] = ip_next[7:4];
            s_d.mem[IDX_W15_LO] = ip_next[3:0];
            s_d.depth           = 1'b1;                        // [RULE5]
            s_d.ip              = exec_arg;
          end
        end
        // Back to saved point
        FBC_RETURN: begin
          if (!s_q.depth) begin
            // Return with nothing saved is a fault          [RULE6]
            s_d.hang = 1'b1;
            s_d.ip   = s_q.ip;
          end else begin
            // Store keeps its value after the return         [RULE8]
            s_d.ip    = {s_q.ras_hi, s_q.mem[IDX_W15_HI],
                         s_q.mem[IDX_W15_LO]};                 // [RULE4]
            s_d.depth = 1'b0;                                  // [RULE5]
          end
        end
        // Logical and
        FBC_AND: begin
          s_d.acc   = a & exec_arg[3:0];                       // [RULE15]
          s_d.carry = a[3] & exec_arg[3];                      // [RULE21]
        end
        // Logical xor
        FBC_XOR: begin
          s_d.acc   = a ^ exec_arg[3:0];
          s_d.carry = a[3] & exec_arg[3];                      // [RULE21]
        end
        // Logical or
        FBC_OR: begin
          s_d.acc   = a | exec_arg[3:0];
          s_d.carry = 1'b0;                                    // [RULE24]
        end
        // Circular rotate
        FBC_ROT: begin
          s_d.acc   = {a[2:0], a[3]};
          s_d.carry = a[3];                                    // [RULE22]
        end
        // Shift, zero in
        FBC_ROT_ZERO: begin
          s_d.acc   = {a[2:0], 1'b0};
          s_d.carry = a[3];                                    // [RULE22]
        end
        // Increment, wraps
        FBC_INC: begin
          s_d.acc   = a + 4'h1;
          s_d.carry = (a == 4'hF);                             // [RULE23]
        end
        FBC_SET_CARRY: begin
          // Flag only; the accumulator keeps its value
          s_d.carry = (a == 4'hF);                             // [RULE23]
        end
        // Load immediate
        FBC_MOVE_IMM: begin
          s_d.acc   = exec_arg[3:0];
          s_d.carry = 1'b0;                                    // [RULE24]
        end
        // Load data word
        FBC_MOVE_LOAD: begin
          s_d.acc   = s_q.mem[eidx];
          s_d.carry = 1'b0;                                    // [RULE24]
        end
        // Write data word
        FBC_STORE: begin
          // Carry untouched by a store                      [RULE26]
          s_d.mem[eidx] = a;                                   // [RULE9]
        end
        // Read key pins
        FBC_PORT_IN: begin
          s_d.acc   = key_f;
          s_d.carry = 1'b0;                                    // [RULE24]
        end
        // Status test
        FBC_TEST: begin
          // Key and timer terms from the low operand bits   [RULE19]
          if (tsel == TST_KEY_A || tsel == TST_KEY_B ||
              tsel == TST_KEY_C) begin
            cond = |key_f;
          end else if (tsel == TST_TMR) begin
            cond = timer_zero;
          end
          // Sense terms trust software set the modes   [RULE19] [RULE20]
          if (exec_arg[TST_SPECIAL_BIT]) begin
            cond = cond | s_q.filt[PIN_SA] | s_q.filt[PIN_SB] |
                   (s_q.cr1[CR1_STOP_BIT] & s_q.filt[PIN_SC]);
          end
          s_d.status = cond;                                   // [RULE16]
        end
        // Halt or stay awake
        FBC_HALT: begin
          if (release_now) begin
            s_d.status = 1'b1;                                 // [RULE17]
          end else if (s_q.status) begin
            s_d.status = 1'b0;                                 // [RULE18]
          end else begin
            s_d.standby = 1'b1;
          end
        end
        default: begin
          s_d.ip = ip_next;           // Illegal code acts as no-op
        end
      endcase
    end

    // Leaving standby once the release condition appears
    if (s_q.standby && release_now && !do_rst) begin
      s_d.standby = 1'b0;
      s_d.status  = 1'b1;                                      // [RULE17]
    end

    // Reserved test steps and beyond send fetch home  [RULE10] [RULE11]
    if (s_d.ip >= IP_TEST_BASE) begin
      s_d.ip = IP_RESET;
    end

    // Synchronous reset; accumulator and other words keep their value
    if (do_rst) begin
      s_d.ip             = IP_RESET;                           // [RULE1]
      s_d.depth          = 1'b0;                               // [RULE7]
      s_d.mem[IDX_W0_LO] = 4'h0;                               // [RULE13]
      s_d.mem[IDX_W0_HI] = 4'h0;                               // [RULE13]
      s_d.cr0            = CR0_RST;                            // [RULE25]
      s_d.cr0[CR0_RET_BIT] = ~s_q.filt[PIN_SUP];               // [RULE25]
      s_d.cr1            = CR1_RST;
      s_d.status         = 1'b0;
      s_d.standby        = 1'b0;
      s_d.hang           = 1'b0;
      s_d.rdata          = 8'h00;
    end

    // Table pointer follows its sources, zero after reset       [RULE14]
    s_d.tp = {s_d.cr0[7:4], s_d.mem[IDX_W0_HI], s_d.mem[IDX_W0_LO]};
  end

  //////////////////////////////////////////////////////////////////////////
  // State register

  // Single clock; reset is folded into the next-state logic
  always_ff @(posedge sys_clk) begin
    s_q <= s_d;                                                // [RULE27]
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs, each straight from the state register

  assign reg_rdata           = s_q.rdata;
  assign instruction_pointer = s_q.ip;                         // [RULE1]
  assign table_pointer       = s_q.tp;
  assign accumulator         = s_q.acc;
  assign carry_flag          = s_q.carry;
  assign status_flag         = s_q.status;
  assign standby             = s_q.standby;
  assign system_reset        = s_q.hang;                       // [RULE6]

endmodule

// ===== hw/fbc_pkg.sv
// Shared constants, types and state layout for the 4-bit core control block
package fbc_pkg;

  // Widths
  localparam int IP_W   = 12;              // Instruction pointer width
  localparam int NIB_W  = 4;               // Data word width
  localparam int MEM_N  = 128;             // Four pages of 32 words
  localparam int PIN_N  = 8;               // Synchronised pin inputs
  localparam int LEN_W  = 2;               // Instruction length field

  // Program memory map
  localparam logic [11:0] IP_RESET     = 12'h000;  // Restart address
  localparam logic [11:0] IP_TEST_BASE = 12'hFEA;  // First reserved step

  // Data memory locations in page zero
  localparam logic [6:0] IDX_W0_LO  = 7'h00;   // Word zero, low nibble
  localparam logic [6:0] IDX_W0_HI  = 7'h10;   // Word zero, high nibble
  localparam logic [6:0] IDX_W15_LO = 7'h0F;   // Word fifteen, low nibble
  localparam logic [6:0] IDX_W15_HI = 7'h1F;   // Word fifteen, high nibble

  // Register port map
  localparam logic [7:0] ADDR_MEM_TOP = 8'h1F;  // Last data word of page
  localparam logic [7:0] ADDR_CR0     = 8'h20;  // Control register zero
  localparam logic [7:0] ADDR_CR1     = 8'h21;  // Control register one
  localparam logic [7:0] ADDR_STAT    = 8'h22;  // Core status
  localparam logic [7:0] ADDR_ACC     = 8'h23;  // Accumulator

  // Control register fields and reset values
  localparam int CR0_RET_BIT   = 3;           // Retention flag position
  localparam int CR1_STOP_BIT  = 3;           // Stop release for pin c
  localparam logic [7:0] CR0_RST = 8'h00;     // Retention bit patched in
  localparam logic [7:0] CR1_RST = 8'h26;     // Port mode defaults

  // Pin vector positions
  localparam int PIN_SA  = 4;                 // Sense pin a
  localparam int PIN_SB  = 5;                 // Sense pin b
  localparam int PIN_SC  = 6;                 // Sense pin c
  localparam int PIN_SUP = 7;                 // Supply low detector

  // Status-test operand codes
  localparam logic [2:0] TST_KEY_A = 3'h0;    // Any key pin high
  localparam logic [2:0] TST_KEY_B = 3'h3;    // Any key pin high
  localparam logic [2:0] TST_KEY_C = 3'h6;    // Any key pin high
  localparam logic [2:0] TST_TMR   = 3'h5;    // Timer down counter zero
  localparam int TST_SPECIAL_BIT   = 3;       // Adds sense-pin terms

  // Decoded instruction classes
  typedef enum logic [4:0] {
    FBC_NOP       = 5'b00000,
    FBC_JMP       = 5'b00001,
    FBC_JC        = 5'b00010,
    FBC_JNC       = 5'b00011,
    FBC_JF        = 5'b00100,
    FBC_JNF       = 5'b00101,
    FBC_CALL      = 5'b00110,
    FBC_RETURN    = 5'b00111,
    FBC_AND       = 5'b01000,
    FBC_XOR       = 5'b01001,
    FBC_OR        = 5'b01010,
    FBC_ROT       = 5'b01011,
    FBC_ROT_ZERO  = 5'b01100,
    FBC_INC       = 5'b01101,
    FBC_SET_CARRY = 5'b01110,
    FBC_MOVE_IMM  = 5'b01111,
    FBC_MOVE_LOAD = 5'b10000,
    FBC_STORE     = 5'b10001,
    FBC_PORT_IN   = 5'b10010,
    FBC_TEST      = 5'b10011,
    FBC_HALT      = 5'b10100
  } fbc_op_e;

  // Whole state of the core control block
  typedef struct packed {
    logic [IP_W-1:0]             ip;       // Instruction pointer
    logic [NIB_W-1:0]            ras_hi;   // Return store, upper bits
    logic                        depth;    // Return depth pointer
    logic [NIB_W-1:0]            acc;      // Accumulator
    logic                        carry;    // Carry flag
    logic                        status;   // Status flag
    logic                        standby;  // Halted, waiting for release
    logic                        hang;     // Stack fault reset pulse
    logic [7:0]                  cr0;      // Control register zero
    logic [7:0]                  cr1;      // Control register one
    logic [MEM_N-1:0][NIB_W-1:0] mem;      // Data memory
    logic [IP_W-1:0]             tp;       // Table pointer
    logic [7:0]                  rdata;    // Register port read data
    logic [PIN_N-1:0]            s1;       // Pin sync stage one
    logic [PIN_N-1:0]            s2;       // Pin sync stage two
    logic [PIN_N-1:0]            s3;       // Pin sync stage three
    logic [PIN_N-1:0]            filt;     // Agreed pin levels
  } fbc_state_s;

endpackage

// ===== verification/fbc_core_assertions.sv
// Concurrent checks on the ports of the core control block
`timescale 1ns/1ps
module fbc_core_chk
  import fbc_pkg::*;
(
  input wire logic            sys_clk,
  input wire logic            rst,
  input wire logic            exec_valid,
  input wire fbc_op_e         exec_op,
  input wire logic [IP_W-1:0] exec_arg,
  input wire logic [LEN_W-1:0] exec_len,
  input wire logic            timer_zero,
  input wire logic [IP_W-1:0] instruction_pointer,
  input wire logic [IP_W-1:0] table_pointer,
  input wire logic [NIB_W-1:0] accumulator,
  input wire logic            carry_flag,
  input wire logic            status_flag,
  input wire logic            standby,
  input wire logic            system_reset
);
  // Instruction really executes: standby and fault pulse block it
  wire taken = exec_valid && !standby && !system_reset;

  default clocking cb @(posedge sys_clk); endclocking

  ////////////////////////////////////////////////////////////////////////
  // Pointer flow
  a_reset_ip:
  assert property (rst |=> instruction_pointer == 12'h000)
    else $error("pointer not zero after reset");
  a_reset_table:
  assert property (rst |=> table_pointer == 12'h000)
    else $error("table pointer not zero after reset");
  a_seq_advance:
  assert property (disable iff (rst)
    (taken && exec_op inside {FBC_AND, FBC_OR, FBC_INC, FBC_NOP}
     && instruction_pointer < 12'hF00)
    |=> instruction_pointer == $past(instruction_pointer + 12'(exec_len)))
    else $error("pointer did not advance by length");
  a_jump_load:
  assert property (disable iff (rst)
    (taken && exec_op == FBC_JMP && exec_arg < 12'hFEA)
    |=> instruction_pointer == $past(exec_arg))
    else $error("jump target not loaded");
  a_jump_reserved:
  assert property (disable iff (rst)
    (taken && exec_op == FBC_JMP && exec_arg >= 12'hFEA)
    |=> instruction_pointer == 12'h000)
    else $error("reserved target not redirected");
  a_fault_restart:
  assert property (disable iff (rst)
    system_reset |=> instruction_pointer == 12'h000 && !system_reset)
    else $error("fault did not restart at zero");

  ////////////////////////////////////////////////////////////////////////
  // Carry and status flags
  a_carry_logic:
  assert property (disable iff (rst)
    (taken && exec_op inside {FBC_AND, FBC_XOR})
    |=> carry_flag == $past(accumulator[3] & exec_arg[3]))
    else $error("logic carry wrong");
  a_carry_rot:
  assert property (disable iff (rst)
    (taken && exec_op inside {FBC_ROT, FBC_ROT_ZERO})
    |=> carry_flag == $past(accumulator[3]))
    else $error("rotate carry wrong");
  a_carry_full:
  assert property (disable iff (rst)
    (taken && exec_op inside {FBC_INC, FBC_SET_CARRY})
    |=> carry_flag == ($past(accumulator) == 4'hF))
    else $error("increment carry wrong");
  a_carry_clear:
  assert property (disable iff (rst)
    (taken && exec_op inside {FBC_OR, FBC_MOVE_IMM, FBC_PORT_IN})
    |=> !carry_flag)
    else $error("carry not cleared");
  a_carry_keep:
  assert property (disable iff (rst)
    (taken && exec_op inside {FBC_NOP, FBC_JMP}) |=> $stable(carry_flag))
    else $error("carry changed unexpectedly");
  a_test_timer:
  assert property (disable iff (rst)
    (taken && exec_op == FBC_TEST && exec_arg[3:0] == 4'h5)
    |=> status_flag == $past(timer_zero))
    else $error("timer status test wrong");
endmodule

bind fbc_core fbc_core_chk u_chk (.*);

// ===== verification/fbc_rom_model.sv
// Program store model: hands the core a short fetched program
`timescale 1ns/1ps
module fbc_rom_model
  import fbc_pkg::*;
(
  input  wire logic [IP_W-1:0]  ip,
  output fbc_op_e               op,
  output logic [IP_W-1:0]       arg,
  output logic [LEN_W-1:0]      len
);
  // Unprogrammed steps read as one-step no-ops
  always_comb begin
    op = FBC_NOP;
    arg = 12'h000;
    len = 2'h1;
    case (ip)
      12'h000: begin
        op = FBC_CALL; // Nest one level only
        arg = 12'h010;
      end
      12'h010: op = FBC_RETURN;
      12'h001: begin
        op = FBC_JMP;
        arg = 12'hFE9;
      end
      12'hFE9: len = 2'h2; // Runs into the reserved area
      default: ;
    endcase
  end
endmodule

// ===== verification/tb_top.sv
// Self-checking bench for the core control block
`timescale 1ns/1ps
module tb_top
  import fbc_pkg::*;
;
  typedef struct packed {
    fbc_op_e op; logic [11:0] arg; logic [1:0] len;
    logic [3:0] acc; logic cy; logic [11:0] ip;
  } fbc_row_s;
  // Straight-line rows: op, operand, length, then acc, carry, pointer
  fbc_row_s rows [16] = '{
    '{FBC_MOVE_IMM,12'h009,2'h1,4'h9,1'b0,12'h001},
    '{FBC_AND,12'h00C,2'h1,4'h8,1'b1,12'h002},
    '{FBC_XOR,12'h008,2'h1,4'h0,1'b1,12'h003},
    '{FBC_OR,12'h005,2'h1,4'h5,1'b0,12'h004},
    '{FBC_ROT,12'h000,2'h1,4'hA,1'b0,12'h005},
    '{FBC_ROT,12'h000,2'h1,4'h5,1'b1,12'h006},
    '{FBC_NOP,12'h000,2'h2,4'h5,1'b1,12'h008},
    '{FBC_MOVE_IMM,12'h00F,2'h1,4'hF,1'b0,12'h009},
    '{FBC_SET_CARRY,12'h000,2'h1,4'hF,1'b1,12'h00A},
    '{FBC_INC,12'h000,2'h1,4'h0,1'b1,12'h00B},
    '{FBC_INC,12'h000,2'h1,4'h1,1'b0,12'h00C},
    '{FBC_MOVE_IMM,12'h008,2'h2,4'h8,1'b0,12'h00E},
    '{FBC_ROT_ZERO,12'h000,2'h1,4'h0,1'b1,12'h00F},
    '{FBC_JMP,12'h123,2'h1,4'h0,1'b1,12'h123},
    '{FBC_JC,12'h200,2'h1,4'h0,1'b1,12'h200},
    '{FBC_JNC,12'h300,2'h1,4'h0,1'b1,12'h201}};
  logic [11:0] rom_ip [4] = '{12'h010, 12'h001, 12'hFE9, 12'h000};
  logic        sys_clk, rst, b_v, rom_on, x_v, reg_wr, reg_rd;
  logic        sa, sb, sc, sup, tz, cy, st, sby, srst;
  fbc_op_e     b_op, r_op, x_op;
  logic [11:0] b_arg, r_arg, x_arg, ip, tp;
  logic [1:0]  b_len, r_len, x_len;
  logic [3:0]  keys, acc;
  logic [7:0]  ra, rw, rdat, v;
  int          n_errors, samples_checked, i;

  // Fetched program or bench rows feed the instruction port
  assign x_v = rom_on | b_v;
  assign x_op = rom_on ? r_op : b_op;
  assign x_arg = rom_on ? r_arg : b_arg;
  assign x_len = rom_on ? r_len : b_len;

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  fbc_rom_model u_rom (.ip(ip), .op(r_op), .arg(r_arg), .len(r_len));
  fbc_core dut (
    .sys_clk(sys_clk), .rst(rst), .exec_valid(x_v), .exec_op(x_op),
    .exec_arg(x_arg), .exec_len(x_len), .key_inputs(keys),
    .sense_pin_a(sa), .sense_pin_b(sb), .sense_pin_c(sc),
    .supply_low(sup), .timer_zero(tz), .reg_addr(ra), .reg_wdata(rw),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdat),
    .instruction_pointer(ip), .table_pointer(tp), .accumulator(acc),
    .carry_flag(cy), .status_flag(st), .standby(sby),
    .system_reset(srst));

  ////////////////////////////////////////////////////////////////////////
  // Compare, drive and close
  task automatic chk(input logic [11:0] g, input logic [11:0] e);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic ex(input fbc_op_e o, input logic [11:0] a,
                    input logic [1:0] l);
    @(posedge sys_clk);
    b_v <= 1'b1;
    b_op <= o;
    b_arg <= a;
    b_len <= l;
    @(posedge sys_clk);
    b_v <= 1'b0;
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    ra <= a;
    rw <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // Data stands only in the cycle after the strobe
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    ra <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    v = rdat;
    chk(v, e);
  endtask
  task automatic flt();
    chk(srst, 1'b1);
    @(posedge sys_clk);
    #1;
    chk(ip, 12'h000);
  endtask
  task automatic summarize();
    $display("errors=%0d checks=%0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Hang guard at 10000 cycles, far beyond the 150 or so cycles needed
  initial begin
    #40000;
    n_errors++;
    summarize();
  end

  initial begin
    {rst, b_v, rom_on, reg_wr, reg_rd, sa, sb, sc, sup, tz} = 10'h200;
    {ra, rw, b_arg, b_len, keys} = '0;
    b_op = FBC_NOP;
    n_errors = 0;
    samples_checked = 0;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    #1;
    chk(ip, 12'h000);
    // Carry known before the fetched program runs
    ex(FBC_MOVE_IMM, 12'h000, 2'h0);
    // Fetched program: call, return, jump, reserved wrap
    @(posedge sys_clk);
    rom_on <= 1'b1;
    for (i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      if (i == 3) rom_on <= 1'b0;
      #1;
      chk(ip, rom_ip[i]);
    end
    foreach (rows[k]) begin
      ex(rows[k].op, rows[k].arg, rows[k].len);
      chk(acc, rows[k].acc);
      chk(cy, rows[k].cy);
      chk(ip, rows[k].ip);
    end
    // Call saves the return point, return restores it
    ex(FBC_CALL, 12'h050, 2'h1);
    chk(ip, 12'h050);
    rc(8'h22, 8'h09);
    rc(8'h0F, 8'h02);
    ex(FBC_RETURN, 12'h000, 2'h1);
    chk(ip, 12'h202);
    rc(8'h0F, 8'h02);
    ex(FBC_RETURN, 12'h000, 2'h1);
    flt();
    ex(FBC_CALL, 12'h060, 2'h1);
    ex(FBC_CALL, 12'h070, 2'h1);
    flt();
    rc(8'h22, 8'h01);
    ex(FBC_JMP, 12'hFEA, 2'h1);
    chk(ip, 12'h000);
    // Status tests: timer, keys, halt variants
    tz <= 1'b1;
    ex(FBC_TEST, 12'h005, 2'h1);
    chk(st, 1'b1);
    tz <= 1'b0;
    ex(FBC_TEST, 12'h005, 2'h1);
    chk(st, 1'b0);
    keys <= 4'h8;
    repeat (6) @(posedge sys_clk);
    ex(FBC_TEST, 12'h006, 2'h1);
    chk(st, 1'b1);
    keys <= 4'h0;
    repeat (6) @(posedge sys_clk);
    ex(FBC_HALT, 12'h000, 2'h1);
    chk({st, sby}, 2'b00);
    ex(FBC_HALT, 12'h000, 2'h1);
    chk(sby, 1'b1);
    keys <= 4'h1;
    for (i = 0; i < 20 && sby !== 1'b0; i++) #4;
    #1;
    chk({st, sby}, 2'b10);
    ex(FBC_HALT, 12'h000, 2'h1);
    chk({st, sby}, 2'b10);
    keys <= 4'h0;
    // Register port, paging, table pointer, reset
    rc(8'h20, 8'h08);
    rc(8'h21, 8'h26);
    rc(8'h30, 8'h00);
    wr(8'h00, 8'h03);
    wr(8'h10, 8'h04);
    wr(8'h20, 8'h50);
    repeat (2) @(posedge sys_clk);
    #1;
    chk(tp, 12'h543);
    wr(8'h02, 8'h0A);
    wr(8'h20, 8'h51);
    wr(8'h02, 8'h06);
    rc(8'h02, 8'h06);
    wr(8'h20, 8'h50);
    rc(8'h02, 8'h0A);
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    #1;
    chk(tp, 12'h000);
    rc(8'h00, 8'h00);
    rc(8'h02, 8'h0A);
    rc(8'h20, 8'h08);
    // Sense pin c counts once software enables it
    wr(8'h21, 8'h2B);
    sc <= 1'b1;
    repeat (6) @(posedge sys_clk);
    ex(FBC_TEST, 12'h009, 2'h1);
    chk(st, 1'b1);
    sc <= 1'b0;
    repeat (6) @(posedge sys_clk);
    ex(FBC_TEST, 12'h009, 2'h1);
    chk(st, 1'b0);
    summarize();
  end
endmodule
